// ---- sbus_cfg_pkg.sv ----
package sbus_cfg_pkg;

  // Channel count and register widths
  localparam int NUM_CHAN = 4;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register indices within a channel window
  localparam logic [2:0] IDX_ENABLE = 3'h0;
  localparam logic [2:0] IDX_POLY = 3'h1;
  localparam logic [2:0] IDX_SEED = 3'h2;
  localparam logic [2:0] IDX_LENGTH = 3'h3;
  localparam logic [2:0] IDX_SPREAD = 3'h4;
  localparam logic [2:0] IDX_PERIOD = 3'h5;

  // Global map: channel n at n*8, revision register alone
  localparam logic [ADDR_W-1:0] ADDR_REVISION = 6'h20;
  localparam logic ADDR_REV_MSB = 1'h1;

  // Enable register fields
  localparam int EN_POS = 0;
  localparam int LOW_SW_POS = 1;
  localparam int HIGH_SW_POS = 2;

  // Length register fields
  localparam int SHORT_WORD_BITS_LSB = 4;
  localparam int SHORT_WORD_BITS_TOP = 7;
  localparam int CRC_BITS_LSB = 0;
  localparam logic [3:0] CRC_LEN_MAX = 4'h8;

  // Revision register fields
  localparam int FUSE_ERR_POS = 7;

  // Reset values
  localparam logic [7:0] POLY_RST = 8'h11;
  localparam logic [7:0] SEED_RST = 8'h0A;
  localparam logic [7:0] LENGTH_RST = 8'h84;
  localparam logic [7:0] SPREAD_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h28;

  // Bit time base: (BASE_OFFSET + 2x) ticks of 1/(16*fclk)
  localparam logic [9:0] BASE_OFFSET = 10'h140;

  // Deviation maxima in 1/64 MHz periods
  localparam logic [6:0] DEV_MAX_1 = 7'h10;
  localparam logic [6:0] DEV_MAX_2 = 7'h20;
  localparam logic [6:0] DEV_MAX_3 = 7'h40;
  localparam logic [6:0] DEV_MAX_4 = 7'h4E;

  // Random source seed
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

endpackage

// ---- sbus_chan_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none

module sbus_chan_cfg #(
  parameter int NCH = sbus_cfg_pkg::NUM_CHAN,
  parameter int FUSE_W = 16,
  parameter logic [6:0] REVISION_ID = 7'h2A // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register access from serial front end
  input wire logic [sbus_cfg_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_sel,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Fault events from analog and protection logic
  input wire logic [NCH-1:0] i_thermal_sd,
  input wire logic [NCH-1:0] i_signal_drive_lockout,
  input wire logic i_switch_thermal_limit,
  // Fuse check inputs
  input wire logic [FUSE_W-1:0] i_fuse_bits,
  input wire logic i_fuse_parity_stored,
  input wire logic i_fuse_trimmed,
  // Protocol engine handshake
  input wire logic [NCH-1:0] i_txn_start,
  input wire logic [NCH-1:0] i_bit_tick,
  output logic [NCH-1:0] o_abort,
  output logic [NCH-1:0] o_chan_clear,
  output logic [NCH-1:0] o_chan_enable,
  // Applied settings for the engine
  output logic [8*NCH-1:0] o_crc_poly,
  output logic [8*NCH-1:0] o_crc_seed,
  output logic [4*NCH-1:0] o_short_word_bits,
  output logic [4*NCH-1:0] o_crc_bits,
  output logic [10*NCH-1:0] o_base_ticks,
  output logic [7*NCH-1:0] o_dev_steps,
  // Channel 0 pseudo bus switches
  output logic o_low_switch_close,
  output logic o_high_switch_close
);
  import sbus_cfg_pkg::*;

  // Per-channel shadow and applied buses
  logic [8*NCH-1:0] rd_word;
  logic [3*NCH-1:0] dev_applied;
  logic [8*NCH-1:0] period_applied;
  logic [NCH-1:0] low_sw;
  logic [NCH-1:0] high_sw;

  // Revision register and fuse check
  logic fuse_err_reg;
  logic fuse_done_reg;
  logic fuse_calc;
  logic rev_hit;
  logic [7:0] rev_word;
  logic [2:0] chan_of_addr;
  logic [7:0] rd_next;

  // Address decode shared by all channels
  assign rev_hit = (i_reg_addr[5] == ADDR_REV_MSB);
  assign chan_of_addr = {1'b0, i_reg_addr[4:3]};
  assign fuse_calc = ^i_fuse_bits;
  assign rev_word = {fuse_err_reg, REVISION_ID};

  // Fuse parity captured once after reset release
  // An untrimmed part always flags an error
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fuse_done_reg <= 1'b0;
      fuse_err_reg <= 1'b0;
    end else if (!fuse_done_reg) begin
      fuse_done_reg <= 1'b1;
      fuse_err_reg <= (fuse_calc != i_fuse_parity_stored) |
                      !i_fuse_trimmed;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Control bits of the enable register
      logic en_reg;
      logic low_reg;
      logic high_reg;
      logic en_next;
      logic low_next;
      logic high_next;
      // Shadow copies seen by software
      logic [7:0] poly_reg;
      logic [7:0] seed_reg;
      logic [7:0] len_reg;
      logic [7:0] ss_reg;
      logic [7:0] per_reg;
      // Applied copies seen by the engine
      logic [7:0] poly_act_reg;
      logic [7:0] seed_act_reg;
      logic [7:0] len_act_reg;
      logic [7:0] ss_act_reg;
      logic [7:0] per_act_reg;
      // Decode and fault terms
      logic chan_hit;
      logic wr_en_reg;
      logic cfg_hit;
      logic cfg_wr;
      logic wr_poly;
      logic wr_seed;
      logic wr_len;
      logic wr_ss;
      logic wr_per;
      logic sw_fault;
      logic en_fault;
      // Write clamps, mask and read word
      logic [3:0] sw_wr;
      logic [3:0] crc_wr;
      logic [7:0] len_wr;
      logic [7:0] crc_mask;
      logic [7:0] rd_mux;

      // Decode of this channel's window
      assign chan_hit = !rev_hit && (chan_of_addr == 3'(g));
      assign wr_en_reg = chan_hit && i_reg_wr &&
                         (i_reg_addr[2:0] == IDX_ENABLE);
      assign cfg_hit = chan_hit && (i_reg_addr[2:0] != IDX_ENABLE) &&
                       (i_reg_addr[2:0] <= IDX_PERIOD);
      assign cfg_wr = cfg_hit && i_reg_wr;
      // One write select per shadow register
      assign wr_poly = cfg_wr && (i_reg_addr[2:0] == IDX_POLY);
      assign wr_seed = cfg_wr && (i_reg_addr[2:0] == IDX_SEED);
      assign wr_len = cfg_wr && (i_reg_addr[2:0] == IDX_LENGTH);
      assign wr_ss = cfg_wr && (i_reg_addr[2:0] == IDX_SPREAD);
      assign wr_per = cfg_wr && (i_reg_addr[2:0] == IDX_PERIOD);

      // Abort holds through the write to a config register
      assign o_abort[g] = cfg_hit && i_reg_sel;
      // Channel kept cleared while disabled or during a config write
      assign o_chan_clear[g] = !en_reg || cfg_wr;
      assign o_chan_enable[g] = en_reg;

      // Length write with clamps
      assign sw_wr = {1'b1, i_reg_wdata[SHORT_WORD_BITS_LSB +: 3]};
      assign crc_wr = (i_reg_wdata[CRC_BITS_LSB +: 4] > CRC_LEN_MAX) ?
                      CRC_LEN_MAX : i_reg_wdata[CRC_BITS_LSB +: 4];
      assign len_wr = {sw_wr, crc_wr};

      // Fault sources; thermal and lockout drop enable
      assign en_fault = i_thermal_sd[g] ||
                        i_signal_drive_lockout[g];
      assign sw_fault = en_fault || i_switch_thermal_limit;

      // Enable and switch next state; faults beat writes
      assign en_next = en_fault ? 1'b0 :
                       wr_en_reg ? i_reg_wdata[EN_POS] : en_reg;
      assign low_next = (sw_fault || !en_next) ? 1'b0 :
                        wr_en_reg ? i_reg_wdata[LOW_SW_POS] :
                        low_reg;
      assign high_next = (sw_fault || !en_next) ? 1'b0 :
                         wr_en_reg ? i_reg_wdata[HIGH_SW_POS] :
                         high_reg;

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          en_reg <= 1'b0;
          low_reg <= 1'b0;
          high_reg <= 1'b0;
        end else begin
          en_reg <= en_next;
          // Switches exist on channel 0 only
          low_reg <= (g == 0) ? low_next : 1'b0;
          high_reg <= (g == 0) ? high_next : 1'b0;
        end
      end

      // Shadow copies written by software
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          poly_reg <= POLY_RST;
          seed_reg <= SEED_RST;
          len_reg <= LENGTH_RST;
          ss_reg <= SPREAD_RST;
          per_reg <= PERIOD_RST;
        end else begin
          if (wr_poly) begin
            poly_reg <= i_reg_wdata;
          end
          if (wr_seed) begin
            seed_reg <= i_reg_wdata;
          end
          if (wr_len) begin
            len_reg <= len_wr;
          end
          if (wr_ss) begin
            ss_reg <= {5'h00, i_reg_wdata[2:0]};
          end
          if (wr_per) begin
            per_reg <= i_reg_wdata;
          end
        end
      end

      // Applied copies taken at transaction start
      // Abort blocks a start during a config write
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          poly_act_reg <= POLY_RST;
          seed_act_reg <= SEED_RST;
          len_act_reg <= LENGTH_RST;
          ss_act_reg <= SPREAD_RST;
          per_act_reg <= PERIOD_RST;
        end else if (i_txn_start[g] && !o_abort[g]) begin
          poly_act_reg <= poly_reg;
          seed_act_reg <= seed_reg;
          len_act_reg <= len_reg;
          ss_act_reg <= ss_reg;
          per_act_reg <= per_reg;
        end
      end

      // Mask terms above CRC length; top term implied by engine
      // Length 0 masks every bit
      assign crc_mask = 8'(16'h00FF >> (4'h8 - len_act_reg[3:0]));
      assign o_crc_poly[8*g +: 8] = poly_act_reg & crc_mask;
      assign o_crc_seed[8*g +: 8] = seed_act_reg & crc_mask;
      assign o_short_word_bits[4*g +: 4] = len_act_reg[7:4];
      assign o_crc_bits[4*g +: 4] = len_act_reg[3:0];
      assign dev_applied[3*g +: 3] = ss_act_reg[2:0];
      assign period_applied[8*g +: 8] = per_act_reg;
      assign low_sw[g] = low_reg;
      assign high_sw[g] = high_reg;

      // Read selection of this channel
      assign rd_mux =
        (i_reg_addr[2:0] == IDX_ENABLE) ?
          {5'h00, high_reg, low_reg, en_reg} :
        (i_reg_addr[2:0] == IDX_POLY) ? poly_reg :
        (i_reg_addr[2:0] == IDX_SEED) ? seed_reg :
        (i_reg_addr[2:0] == IDX_LENGTH) ? len_reg :
        (i_reg_addr[2:0] == IDX_SPREAD) ? ss_reg :
        (i_reg_addr[2:0] == IDX_PERIOD) ? per_reg : 8'h00;
      assign rd_word[8*g +: 8] = rd_mux;
    end
  endgenerate

  // Switch pins show the live state of channel 0
  assign o_low_switch_close = low_sw[0];
  assign o_high_switch_close = high_sw[0];

  // Read data selection; unmapped reads zero
  // Channel slots 6 and 7 also read zero
  assign rd_next = (i_reg_addr == ADDR_REVISION) ? rev_word :
                   rev_hit ? 8'h00 :
                   rd_word[8*i_reg_addr[4:3] +: 8];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_next;
    end
  end

  // Bit time generator from applied settings
  sbus_spread_gen #(
    .NCH(NCH)
  ) u_spread (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_dev_code(dev_applied),
    .i_period_code(period_applied),
    .i_bit_tick(i_bit_tick),
    .o_base_ticks(o_base_ticks),
    .o_dev_steps(o_dev_steps)
  );

endmodule

`default_nettype wire

// ---- sbus_chan_cfg_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module sbus_chan_cfg_chk #(
  parameter int NCH = 4,
  parameter logic [6:0] REVISION_ID = 7'h2A
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register access
  input wire logic [sbus_cfg_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_sel,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Faults
  input wire logic [NCH-1:0] i_thermal_sd,
  input wire logic [NCH-1:0] i_signal_drive_lockout,
  input wire logic i_switch_thermal_limit,
  // Engine side
  input wire logic [NCH-1:0] o_abort,
  input wire logic [NCH-1:0] o_chan_clear,
  input wire logic [NCH-1:0] o_chan_enable,
  input wire logic [8*NCH-1:0] o_crc_poly,
  input wire logic [4*NCH-1:0] o_short_word_bits,
  input wire logic [4*NCH-1:0] o_crc_bits,
  input wire logic [10*NCH-1:0] o_base_ticks,
  input wire logic [7*NCH-1:0] o_dev_steps,
  input wire logic o_low_switch_close,
  input wire logic o_high_switch_close
);
  import sbus_cfg_pkg::*;
  logic cfg0;
  logic fault0;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Config register select and switch faults on channel 0
  assign cfg0 = i_reg_sel && i_reg_addr[5:3] == 3'h0 &&
    i_reg_addr[2:0] >= IDX_POLY && i_reg_addr[2:0] <= IDX_PERIOD;
  assign fault0 = i_thermal_sd[0] || i_signal_drive_lockout[0] ||
    i_switch_thermal_limit;
  chk_abort_hit: assert property (o_abort[0] == cfg0)
    else $error("abort does not match config select");
  chk_low_fault: assert property (fault0 |=> !o_low_switch_close)
    else $error("low switch stays closed after fault");
  chk_high_fault: assert property (fault0 |=> !o_high_switch_close)
    else $error("high switch stays closed after fault");
  chk_dis_opens: assert property ($fell(o_chan_enable[0]) |->
    !o_low_switch_close && !o_high_switch_close)
    else $error("switch closed after disable");
  chk_therm_en: assert property (
    i_thermal_sd[0] |=> !o_chan_enable[0])
    else $error("enable kept after shutdown");
  chk_clear_dis: assert property (
    !o_chan_enable[0] |-> o_chan_clear[0])
    else $error("disabled channel not cleared");
  chk_len_range: assert property (o_short_word_bits[3] &&
    o_crc_bits[3:0] <= CRC_LEN_MAX)
    else $error("length field out of range");
  chk_poly_mask: assert property (
    (o_crc_poly[7:0] >> o_crc_bits[3:0]) == 8'h00)
    else $error("poly bits above length");
  chk_base_even: assert property (o_base_ticks[9:0] >= BASE_OFFSET &&
    !o_base_ticks[0])
    else $error("base ticks malformed");
  chk_dev_max: assert property (
    o_dev_steps[7*NCH-1 -: 7] <= DEV_MAX_4)
    else $error("deviation above maximum");
  chk_rev_read: assert property (i_reg_rd &&
    i_reg_addr == ADDR_REVISION |=> o_reg_rdata[6:0] == REVISION_ID)
    else $error("revision id wrong");
endmodule

bind sbus_chan_cfg sbus_chan_cfg_chk #(.NCH(NCH), .REVISION_ID(REVISION_ID))
  u_sbus_chan_cfg_chk (.i_clk, .i_rst, .i_reg_addr, .i_reg_sel, .i_reg_rd,
  .o_reg_rdata, .i_thermal_sd, .i_signal_drive_lockout,
  .i_switch_thermal_limit, .o_abort, .o_chan_clear, .o_chan_enable,
  .o_crc_poly, .o_short_word_bits, .o_crc_bits, .o_base_ticks,
  .o_dev_steps, .o_low_switch_close, .o_high_switch_close);

`default_nettype wire

// ---- sbus_chan_cfg_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module sbus_chan_cfg_tb_top;
  import sbus_cfg_pkg::*;
  localparam logic [6:0] REV = 7'h35; // Arbitrary value
  localparam logic [7:0] RST_VAL [6] = '{8'h00, 8'h11, 8'h0A, 8'h84,
    8'h00, 8'h28};
  localparam logic [6:0] DMAX [8] = '{7'h00, 7'h10, 7'h20, 7'h40, 7'h4E,
    7'h00, 7'h00, 7'h00};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] fault = 3'h0;
  logic [3:0] txn_start = 4'h0;
  logic [3:0] bit_tick = 4'h0;
  logic fuse_good = 1'b0;
  logic [5:0] addr;
  logic sel, wr, rd, low, high;
  logic [7:0] wdata, rdata, v;
  logic [3:0] abort, clear, en;
  logic [31:0] poly, seed;
  logic [15:0] swb, crcb;
  logic [39:0] base;
  logic [27:0] dev;
  int n_fail = 0;
  int checks = 0;
  // Clock
  always #20 i_clk = ~i_clk;
  sbus_host u_sbus_host (.i_clk(i_clk), .i_reg_rdata(rdata),
    .o_reg_addr(addr), .o_reg_sel(sel), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_wdata(wdata));
  sbus_chan_cfg #(.REVISION_ID(REV)) u_sbus_chan_cfg (.i_clk(i_clk),
    .i_rst(i_rst), .i_reg_addr(addr), .i_reg_sel(sel), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_thermal_sd({3'h0, fault[0]}),
    .i_signal_drive_lockout({3'h0, fault[1]}),
    .i_switch_thermal_limit(fault[2]), .i_fuse_bits(16'h0001),
    .i_fuse_parity_stored(fuse_good), .i_fuse_trimmed(fuse_good),
    .i_txn_start(txn_start), .i_bit_tick(bit_tick), .o_abort(abort),
    .o_chan_clear(clear), .o_chan_enable(en), .o_crc_poly(poly),
    .o_crc_seed(seed), .o_short_word_bits(swb), .o_crc_bits(crcb),
    .o_base_ticks(base), .o_dev_steps(dev), .o_low_switch_close(low),
    .o_high_switch_close(high));
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 6; i++) begin
        u_sbus_host.rd(6'(c * 8 + i), v);
        `CHK(v, RST_VAL[i])
      end
    end
    u_sbus_host.wr(ADDR_REVISION, 8'h00);
    u_sbus_host.wr(6'h30, 8'h55);
    u_sbus_host.rd(ADDR_REVISION, v);
    `CHK(v, {1'b1, REV})
    u_sbus_host.rd(6'h30, v);
    `CHK(v, 8'h00)
    $display("t_reset done");
  endtask
  task automatic t_len;
    logic [15:0] tab [4] = '{16'h3FB8, 16'h79F8, 16'h9090, 16'hF8F8};
    for (int i = 0; i < 4; i++) begin
      u_sbus_host.wr(6'h13, tab[i][15:8]);
      u_sbus_host.rd(6'h13, v);
      `CHK(v, tab[i][7:0])
    end
    $display("t_len done");
  endtask
  task automatic t_apply;
    u_sbus_host.wr(6'h01, 8'h11);
    u_sbus_host.wr(6'h09, 8'h12);
    u_sbus_host.wr(6'h0A, 8'h3C);
    u_sbus_host.wr(6'h0D, 8'hFF);
    u_sbus_host.rd(6'h01, v);
    `CHK(v, 8'h11)
    `CHK({poly[15:8], base[19:10]}, {8'h01, 10'h190})
    @(posedge i_clk);
    txn_start <= 4'h2;
    @(posedge i_clk);
    txn_start <= 4'h0;
    #1;
    `CHK({poly[15:8], seed[15:8]}, 16'h020C)
    `CHK(base[19:10], 10'h33E)
    // Start during a length write is refused, the next one applies
    fork
      u_sbus_host.wr(6'h0B, 8'h93);
      begin
        repeat (2) @(posedge i_clk);
        txn_start <= 4'h2;
        #1;
        `CHK(abort, 4'h2)
        @(posedge i_clk);
        txn_start <= 4'h0;
      end
    join
    #1;
    `CHK({swb[7:4], crcb[7:4]}, 8'h84)
    @(posedge i_clk);
    txn_start <= 4'h2;
    @(posedge i_clk);
    txn_start <= 4'h0;
    #1;
    `CHK({swb[7:4], crcb[7:4]}, 8'h93)
    `CHK({poly[15:8], seed[15:8]}, 16'h0204)
    $display("t_apply done");
  endtask
  task automatic en_chk(input logic [7:0] e);
    u_sbus_host.rd(6'h00, v);
    `CHK(v, e)
    `CHK({high, low, en[0]}, e[2:0])
  endtask
  task automatic hit(input logic [2:0] f);
    u_sbus_host.wr(6'h00, 8'h07);
    @(posedge i_clk);
    fault <= f;
    @(posedge i_clk);
    fault <= 3'h0;
  endtask
  task automatic t_switch;
    u_sbus_host.wr(6'h00, 8'h07);
    en_chk(8'h07);
    u_sbus_host.wr(6'h00, 8'h03);
    en_chk(8'h03);
    hit(3'h4);
    en_chk(8'h01);
    hit(3'h1);
    en_chk(8'h00);
    hit(3'h2);
    en_chk(8'h00);
    u_sbus_host.wr(6'h00, 8'h07);
    u_sbus_host.wr(6'h00, 8'h06);
    en_chk(8'h00);
    `CHK(clear[0], 1'b1)
    $display("t_switch done");
  endtask
  task automatic t_spread;
    logic [6:0] mx;
    for (int c = 0; c < 8; c++) begin
      u_sbus_host.wr(6'h1C, 8'(c));
      u_sbus_host.rd(6'h1C, v);
      `CHK(v, 8'(c))
      mx = 7'h00;
      @(posedge i_clk);
      txn_start <= 4'h8;
      @(posedge i_clk);
      txn_start <= 4'h0;
      bit_tick <= 4'h8; // First draw under the new code
      for (int t = 0; t < 40; t++) begin
        @(posedge i_clk);
        bit_tick <= {t[0], 3'h0};
        #1;
        `CHK(dev[27:21] <= DMAX[c], 1'b1)
        if (dev[27:21] > mx) mx = dev[27:21];
      end
      bit_tick <= 4'h0;
      `CHK(mx != 0, c inside {[1:4]})
    end
    $display("t_spread done");
  endtask
  task automatic t_fuse;
    @(posedge i_clk);
    i_rst <= 1'b1;
    fuse_good <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    u_sbus_host.rd(ADDR_REVISION, v);
    `CHK(v, {1'b0, REV})
    u_sbus_host.rd(6'h09, v);
    `CHK(v, 8'h11)
    $display("t_fuse done");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_len;
    t_apply;
    t_switch;
    t_spread;
    t_fuse;
    results;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    results;
  end
endmodule

`default_nettype wire

// ---- sbus_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module sbus_host (
  // Clock and read data
  input wire logic i_clk,
  input wire logic [7:0] i_reg_rdata,
  // Register requests
  output logic [sbus_cfg_pkg::ADDR_W-1:0] o_reg_addr,
  output logic o_reg_sel,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata
);
  import sbus_cfg_pkg::*;
  // Idle bus, unmapped address
  initial begin
    o_reg_addr = 6'h3F;
    o_reg_sel = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // Write frame: select, strobe, release
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_sel <= 1'b1;
    @(posedge i_clk);
    o_reg_wr <= 1'b1;
    o_reg_wdata <= d;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    o_reg_sel <= 1'b0;
    o_reg_wdata <= ~d; // No stale data after release
  endtask
  // Read strobe, data one edge later
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    #1;
    d = i_reg_rdata;
  endtask
endmodule

`default_nettype wire

// ---- sbus_spread_gen.sv ----
`timescale 1ns/1ps
`default_nettype none

module sbus_spread_gen #(
  parameter int NCH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Applied settings per channel
  input wire logic [3*NCH-1:0] i_dev_code,
  input wire logic [8*NCH-1:0] i_period_code,
  // One pulse per bit time requested by the engine
  input wire logic [NCH-1:0] i_bit_tick,
  // Bit time parts per channel
  output logic [10*NCH-1:0] o_base_ticks,
  output logic [7*NCH-1:0] o_dev_steps
);
  import sbus_cfg_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [15:0] lfsr_reg;
      logic [6:0] dev_reg;
      logic [6:0] dev_max;
      logic [7:0] span;
      logic [15:0] scaled;
      logic [2:0] code;

      // Deviation ceiling by code; spare codes give none
      assign code = i_dev_code[3*g +: 3];
      assign dev_max = (code == 3'h1) ? DEV_MAX_1 :
                       (code == 3'h2) ? DEV_MAX_2 :
                       (code == 3'h3) ? DEV_MAX_3 :
                       (code == 3'h4) ? DEV_MAX_4 : 7'h00;
      // Scale random byte into 0..max
      assign span = {1'b0, dev_max} + 8'h01;
      assign scaled = lfsr_reg[7:0] * span;
      // Minimum bit time (320 + 2x)
      assign o_base_ticks[10*g +: 10] =
        BASE_OFFSET + {1'b0, i_period_code[8*g +: 8], 1'b0};
      assign o_dev_steps[7*g +: 7] = dev_reg;

      // Fresh random deviation each bit time
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          lfsr_reg <= LFSR_SEED;
          dev_reg <= 7'h00;
        end else if (i_bit_tick[g]) begin
          lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                       lfsr_reg[12] ^ lfsr_reg[10]};
          dev_reg <= scaled[14:8];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire
